/* File: core/adcgc_top.v */
// Purpose: Left/right record gain control: PGA, digital volume, fine trim
// Assumes: Classic Wishbone slave, samples and AGC on clk_i
// Notes: Soft steps advance on sample strobes
// Contract
// - PGA code counts 0.5dB steps from 0dB, top code gives 47.5dB
// - Differential adds 6dB; 20k and 40k inputs lose 6dB and 12dB
// - Left and right PGA codes sit in low seven bits of own registers
// - With AGC active the AGC gain replaces the programmed PGA gain
// - Applied PGA moves one 0.5dB step every one or two samples
// - Shared two-bit field can disable stepping for immediate gain
// - After reset PGA stays muted until software writes a gain or enables AGC
// - Power-down ramps PGA to mute in soft steps before channel off
// - Flag bit 7 left, bit 3 right shows PGA applied equals programmed
// - Volume code is two's complement 0.5dB steps, -12dB to +20dB
// - Left and right digital volume registers are independent
// - Digital volume uses the same soft-step field as the PGA
// - Power-down ramps digital volume to -12dB before channel off
// - Same flag bits also require digital volume to have arrived
// - Per-channel fine trim 0 to -0.4dB in 0.1dB steps
// - Sample path itself has unity gain
//
// Decided for this implementation: register access over Wishbone.
`include "adcgc_consts.vh"
`timescale 1ns/100ps
`default_nettype none

// One channel: soft-stepped PGA level, digital volume, power sequencing
module adcgc_chan (
  input wire clk_i,
  input wire rst_i,
  input wire step_i,
  input wire step_off_i,
  input wire pga_set_i,
  input wire [6:0] pga_code_i,
  input wire agc_en_i,
  input wire [6:0] agc_code_i,
  input wire [6:0] dvol_code_i,
  input wire pwr_req_i,
  output wire [6:0] pga_lvl_o,
  output wire [6:0] dvol_o,
  output wire on_o,
  output wire reached_o
);
  reg [6:0] pga_lvl_r;
  reg [6:0] pga_lvl_nxt;
  reg [6:0] dvol_r;
  reg [6:0] dvol_nxt;
  reg armed_r;
  reg on_r;
  reg on_nxt;
  reg [6:0] pga_src;
  reg [6:0] pga_tgt;
  reg [6:0] dvol_clip;
  reg [6:0] dvol_tgt;
  wire dvol_lt;
  wire dvol_gt;

  // Level 0 is mute, level n+1 is PGA code n
  always @* begin
    pga_src = agc_en_i ? agc_code_i : pga_code_i;
    if (pga_src > `ADCGC_PGA_MAX_CODE) begin
      pga_src = `ADCGC_PGA_MAX_CODE;
    end
    if (!armed_r || !pwr_req_i) begin
      pga_tgt = `ADCGC_LVL_MUTE;
    end else begin
      pga_tgt = pga_src + 7'h01;
    end
  end

  // Volume code clipped into its signed range
  always @* begin
    dvol_clip = dvol_code_i;
    if (dvol_code_i[6] && dvol_code_i < `ADCGC_DVOL_MIN) begin
      dvol_clip = `ADCGC_DVOL_MIN;
    end else if (!dvol_code_i[6] && dvol_code_i > `ADCGC_DVOL_MAX) begin
      dvol_clip = `ADCGC_DVOL_MAX;
    end
    dvol_tgt = pwr_req_i ? dvol_clip : `ADCGC_DVOL_MIN;
  end

  assign dvol_lt = $signed(dvol_r) < $signed(dvol_tgt);
  assign dvol_gt = $signed(dvol_r) > $signed(dvol_tgt);

  always @* begin
    pga_lvl_nxt = pga_lvl_r;
    dvol_nxt = dvol_r;
    if (step_off_i) begin
      pga_lvl_nxt = pga_tgt;
      dvol_nxt = dvol_tgt;
    end else if (step_i) begin
      if (pga_lvl_r < pga_tgt) begin
        pga_lvl_nxt = pga_lvl_r + 7'h01;
      end else if (pga_lvl_r > pga_tgt) begin
        pga_lvl_nxt = pga_lvl_r - 7'h01;
      end
      if (dvol_lt) begin
        dvol_nxt = dvol_r + 7'h01;
      end else if (dvol_gt) begin
        dvol_nxt = dvol_r - 7'h01;
      end
    end
  end

  // Channel shuts only once both stages have ramped down
  always @* begin
    on_nxt = on_r;
    if (pwr_req_i) begin
      on_nxt = 1'b1;
    end else if (pga_lvl_r == `ADCGC_LVL_MUTE && dvol_r == `ADCGC_DVOL_MIN) begin
      on_nxt = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pga_lvl_r <= `ADCGC_LVL_MUTE;
      dvol_r <= `ADCGC_DVOL_MIN;
      armed_r <= 1'b0;
      on_r <= 1'b0;
    end else begin
      pga_lvl_r <= pga_lvl_nxt;
      dvol_r <= dvol_nxt;
      on_r <= on_nxt;
      if (pga_set_i || agc_en_i) begin
        armed_r <= 1'b1;
      end
    end
  end

  assign pga_lvl_o = pga_lvl_r;
  assign dvol_o = dvol_r;
  assign on_o = on_r;
  assign reached_o = (pga_lvl_r == pga_tgt) && (dvol_r == dvol_tgt);
endmodule // adcgc_chan

module adcgc_top (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [8:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output wire [31:0] dat_o,
  output wire ack_o,
  input wire sample_valid_i,
  input wire [15:0] sample_l_i,
  input wire [15:0] sample_r_i,
  output wire sample_valid_o,
  output wire [15:0] sample_l_o,
  output wire [15:0] sample_r_o,
  input wire [6:0] agc_gain_l_i,
  input wire [6:0] agc_gain_r_i,
  output wire [6:0] pga_gain_l_o,
  output wire [6:0] pga_gain_r_o,
  output wire pga_mute_l_o,
  output wire pga_mute_r_o,
  output wire [6:0] dvol_l_o,
  output wire [6:0] dvol_r_o,
  output wire [2:0] trim_l_o,
  output wire [2:0] trim_r_o,
  output wire chan_on_l_o,
  output wire chan_on_r_o
);
  reg [6:0] pga_l_r;
  reg [6:0] pga_r_r;
  reg [1:0] step_r;
  reg [7:0] trim_r;
  reg [6:0] dvol_lc_r;
  reg [6:0] dvol_rc_r;
  reg [7:0] ctrl_r;
  reg ack_r;
  reg [31:0] dat_r;
  reg [7:0] rd_nxt;
  reg half_r;
  reg sv_r;
  reg [15:0] sl_r;
  reg [15:0] sr_r;
  reg [2:0] trim_l_nxt;
  reg [2:0] trim_r_nxt;
  wire [6:0] idx;
  wire wr;
  wire step_tick;
  wire step_off;
  wire set_l;
  wire set_r;
  wire [6:0] lvl_l;
  wire [6:0] lvl_r;
  wire [6:0] dv_l;
  wire [6:0] dv_r;
  wire on_l;
  wire on_r;
  wire hit_l;
  wire hit_r;

  assign idx = adr_i[8:2];
  assign wr = cyc_i && stb_i && we_i && sel_i[0] && !ack_r;
  assign set_l = wr && idx == `ADCGC_IDX_PGA_L;
  assign set_r = wr && idx == `ADCGC_IDX_PGA_R;

  // Step pacing from sample strobes
  assign step_off = step_r[1];
  assign step_tick = sample_valid_i && (step_r == `ADCGC_STEP_EVERY1 || half_r);

  always @(posedge clk_i) begin
    if (rst_i) begin
      half_r <= 1'b0;
    end else if (sample_valid_i) begin
      half_r <= !half_r;
    end
  end

  // Register writes; trim fields saturate at the deepest step
  always @* begin
    trim_l_nxt = dat_i[`ADCGC_TRIM_L_LSB+2:`ADCGC_TRIM_L_LSB];
    trim_r_nxt = dat_i[`ADCGC_TRIM_R_LSB+2:`ADCGC_TRIM_R_LSB];
    if (trim_l_nxt > `ADCGC_TRIM_MAX) begin
      trim_l_nxt = `ADCGC_TRIM_MAX;
    end
    if (trim_r_nxt > `ADCGC_TRIM_MAX) begin
      trim_r_nxt = `ADCGC_TRIM_MAX;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      pga_l_r <= `ADCGC_RST_PGA;
      pga_r_r <= `ADCGC_RST_PGA;
      step_r <= `ADCGC_RST_STEP;
      trim_r <= `ADCGC_RST_TRIM;
      dvol_lc_r <= `ADCGC_RST_DVOL;
      dvol_rc_r <= `ADCGC_RST_DVOL;
      ctrl_r <= `ADCGC_RST_CTRL;
    end else if (wr) begin
      case (idx)
        `ADCGC_IDX_PGA_L: begin
          pga_l_r <= dat_i[6:0];
        end
        `ADCGC_IDX_PGA_R: begin
          pga_r_r <= dat_i[6:0];
        end
        `ADCGC_IDX_STEP: begin
          step_r <= dat_i[1:0];
        end
        `ADCGC_IDX_TRIM: begin
          trim_r <= {1'b0, trim_l_nxt, 1'b0, trim_r_nxt};
        end
        `ADCGC_IDX_DVOL_L: begin
          dvol_lc_r <= dat_i[6:0];
        end
        `ADCGC_IDX_DVOL_R: begin
          dvol_rc_r <= dat_i[6:0];
        end
        `ADCGC_IDX_CTRL: begin
          ctrl_r <= dat_i[7:0];
        end
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // Read mux; unmapped indices read zero
  always @* begin
    case (idx)
      `ADCGC_IDX_FLAGS: begin
        rd_nxt = 8'h00;
        rd_nxt[`ADCGC_FLAG_L_BIT] = hit_l;
        rd_nxt[`ADCGC_FLAG_R_BIT] = hit_r;
      end
      `ADCGC_IDX_PGA_L: rd_nxt = {1'b0, pga_l_r};
      `ADCGC_IDX_PGA_R: rd_nxt = {1'b0, pga_r_r};
      `ADCGC_IDX_STEP: rd_nxt = {6'h00, step_r};
      `ADCGC_IDX_TRIM: rd_nxt = trim_r;
      `ADCGC_IDX_DVOL_L: rd_nxt = {1'b0, dvol_lc_r};
      `ADCGC_IDX_DVOL_R: rd_nxt = {1'b0, dvol_rc_r};
      `ADCGC_IDX_CTRL: rd_nxt = ctrl_r;
      `ADCGC_IDX_STAT: rd_nxt = {6'h00, on_r, on_l};
      default: rd_nxt = 8'h00;
    endcase
  end

  // One wait state; ack drops the cycle after it is given
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= cyc_i && stb_i && !ack_r;
      if (cyc_i && stb_i && !ack_r) begin
        dat_r <= {24'h00_0000, rd_nxt};
      end
    end
  end

  adcgc_chan u_left (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .step_i(step_tick),
    .step_off_i(step_off),
    .pga_set_i(set_l),
    .pga_code_i(pga_l_r),
    .agc_en_i(ctrl_r[`ADCGC_CTRL_AGC_L_BIT]),
    .agc_code_i(agc_gain_l_i),
    .dvol_code_i(dvol_lc_r),
    .pwr_req_i(ctrl_r[`ADCGC_CTRL_PWR_L_BIT]),
    .pga_lvl_o(lvl_l),
    .dvol_o(dv_l),
    .on_o(on_l),
    .reached_o(hit_l)
  );

  adcgc_chan u_right (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .step_i(step_tick),
    .step_off_i(step_off),
    .pga_set_i(set_r),
    .pga_code_i(pga_r_r),
    .agc_en_i(ctrl_r[`ADCGC_CTRL_AGC_R_BIT]),
    .agc_code_i(agc_gain_r_i),
    .dvol_code_i(dvol_rc_r),
    .pwr_req_i(ctrl_r[`ADCGC_CTRL_PWR_R_BIT]),
    .pga_lvl_o(lvl_r),
    .dvol_o(dv_r),
    .on_o(on_r),
    .reached_o(hit_r)
  );

  // Unity sample path; silent while a channel is off
  always @(posedge clk_i) begin
    if (rst_i) begin
      sv_r <= 1'b0;
      sl_r <= 16'h0000;
      sr_r <= 16'h0000;
    end else begin
      sv_r <= sample_valid_i;
      if (sample_valid_i) begin
        sl_r <= on_l ? sample_l_i : 16'h0000;
        sr_r <= on_r ? sample_r_i : 16'h0000;
      end
    end
  end

  // Analog stage applies the code; input configuration adds its offset there
  assign pga_gain_l_o = (lvl_l == `ADCGC_LVL_MUTE) ? 7'h00 : lvl_l - 7'h01;
  assign pga_gain_r_o = (lvl_r == `ADCGC_LVL_MUTE) ? 7'h00 : lvl_r - 7'h01;
  assign pga_mute_l_o = (lvl_l == `ADCGC_LVL_MUTE);
  assign pga_mute_r_o = (lvl_r == `ADCGC_LVL_MUTE);
  assign dvol_l_o = dv_l;
  assign dvol_r_o = dv_r;
  assign trim_l_o = trim_r[`ADCGC_TRIM_L_LSB+2:`ADCGC_TRIM_L_LSB];
  assign trim_r_o = trim_r[`ADCGC_TRIM_R_LSB+2:`ADCGC_TRIM_R_LSB];
  assign chan_on_l_o = on_l;
  assign chan_on_r_o = on_r;
  assign sample_valid_o = sv_r;
  assign sample_l_o = sl_r;
  assign sample_r_o = sr_r;
  assign dat_o = dat_r;
  assign ack_o = ack_r;
endmodule // adcgc_top

`default_nettype wire

/* File: core/adcgc_consts.vh */
// Purpose: Constants for the record-channel gain control block
// Assumes: Register index = byte address / 4 on the Wishbone bus
// Notes: Definitions only
`ifndef ADCGC_CONSTS_VH
`define ADCGC_CONSTS_VH

// Register indices (byte address is four times the index)
`define ADCGC_IDX_FLAGS 7'h24
`define ADCGC_IDX_PGA_L 7'h3b
`define ADCGC_IDX_PGA_R 7'h3c
`define ADCGC_IDX_STEP 7'h51
`define ADCGC_IDX_TRIM 7'h52
`define ADCGC_IDX_DVOL_L 7'h53
`define ADCGC_IDX_DVOL_R 7'h54
`define ADCGC_IDX_CTRL 7'h55
`define ADCGC_IDX_STAT 7'h56

// Field positions
`define ADCGC_FLAG_L_BIT 7
`define ADCGC_FLAG_R_BIT 3
`define ADCGC_CTRL_PWR_L_BIT 0
`define ADCGC_CTRL_PWR_R_BIT 1
`define ADCGC_CTRL_AGC_L_BIT 4
`define ADCGC_CTRL_AGC_R_BIT 5
`define ADCGC_TRIM_L_LSB 4
`define ADCGC_TRIM_R_LSB 0

// Reset values
`define ADCGC_RST_PGA 7'h00
`define ADCGC_RST_STEP 2'h0
`define ADCGC_RST_TRIM 8'h00
`define ADCGC_RST_DVOL 7'h00
`define ADCGC_RST_CTRL 8'h00

// Soft-step modes
`define ADCGC_STEP_EVERY1 2'h0
`define ADCGC_STEP_EVERY2 2'h1

// Gain limits
`define ADCGC_PGA_MAX_CODE 7'h5f
`define ADCGC_LVL_MUTE 7'h00
`define ADCGC_DVOL_MIN 7'h68
`define ADCGC_DVOL_MAX 7'h28
`define ADCGC_TRIM_MAX 3'h4

`endif

/* File: test/adcgc_asserts.sv */
// Purpose: Port-level checks of the record gain control block
// Assumes: Synchronous active-high reset, one clock
// Notes: Left channel watched; bound to every adcgc_top
`timescale 1ns/100ps
`default_nettype none
module adcgc_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic sample_valid_i,
  input wire logic [15:0] sample_l_i,
  input wire logic sample_valid_o,
  input wire logic [15:0] sample_l_o,
  input wire logic [6:0] pga_gain_l_o,
  input wire logic pga_mute_l_o,
  input wire logic [6:0] dvol_l_o,
  input wire logic [2:0] trim_l_o,
  input wire logic chan_on_l_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_next_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  rdata_high_a: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  sample_pass_a: assert property (sample_valid_i |=> sample_valid_o &&
    sample_l_o == ($past(chan_on_l_o) ? $past(sample_l_i) : 16'h0000))
    else $error("sample not passed at unity");
  sample_hold_a: assert property (!sample_valid_i |=> !sample_valid_o && $stable(sample_l_o))
    else $error("sample output moved without strobe");
  mute_code_a: assert property (pga_mute_l_o |-> pga_gain_l_o == 7'h00)
    else $error("muted pga shows a gain code");
  trim_max_a: assert property (trim_l_o <= 3'h4)
    else $error("trim above four steps");
  dvol_range_a: assert property (dvol_l_o >= 7'h68 || dvol_l_o <= 7'h28)
    else $error("volume outside range");
  chan_off_a: assert property ($fell(chan_on_l_o) |-> pga_mute_l_o && dvol_l_o == 7'h68)
    else $error("channel off before ramp down");
  cover property (chan_on_l_o && sample_valid_o);
  cover property ($fell(chan_on_l_o));
  cover property (ack_o && trim_l_o == 3'h4);
endmodule // adcgc_asserts

bind adcgc_top adcgc_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .sample_valid_i(sample_valid_i),
  .sample_l_i(sample_l_i), .sample_valid_o(sample_valid_o), .sample_l_o(sample_l_o),
  .pga_gain_l_o(pga_gain_l_o), .pga_mute_l_o(pga_mute_l_o), .dvol_l_o(dvol_l_o),
  .trim_l_o(trim_l_o), .chan_on_l_o(chan_on_l_o));
`default_nettype wire

/* File: test/adc_channel_gain_control_tb_top.sv */
// Purpose: Self-checking bench of the record gain control block
// Assumes: Classic Wishbone, one-cycle ack
// Notes: Read results checked by a monitor against a queue
`include "adcgc_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module adc_channel_gain_control_tb_top;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, sv_i = 0;
  logic [8:0] adr_i = 0;
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0;
  logic [15:0] sl_i = 0, sr_i = 0, lfsr = 16'h4e6c;
  logic [6:0] agc_l = 0;
  logic [6:0] agc_r = 0;
  logic [32:0] sq[$];
  logic [32:0] se;
  wire [31:0] dat_o;
  wire [15:0] sl_o, sr_o;
  wire [6:0] pg_l, pg_r, dv_l, dv_r;
  wire [2:0] tr_l, tr_r;
  wire ack_o, sv_o, mu_l, mu_r, on_l, on_r;
  int fails = 0, n_tests = 0, cyc_n = 0, on_e = 0;
  logic [7:0] q[$];
  logic [6:0] ix[8] = '{`ADCGC_IDX_PGA_L, `ADCGC_IDX_PGA_R, `ADCGC_IDX_STEP,
    `ADCGC_IDX_TRIM, `ADCGC_IDX_DVOL_L, `ADCGC_IDX_DVOL_R, `ADCGC_IDX_CTRL, `ADCGC_IDX_STAT};
  adcgc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .sample_valid_i(sv_i), .sample_l_i(sl_i), .sample_r_i(sr_i), .sample_valid_o(sv_o),
    .sample_l_o(sl_o), .sample_r_o(sr_o), .agc_gain_l_i(agc_l), .agc_gain_r_i(agc_r),
    .pga_gain_l_o(pg_l), .pga_gain_r_o(pg_r), .pga_mute_l_o(mu_l), .pga_mute_r_o(mu_r),
    .dvol_l_o(dv_l), .dvol_r_o(dv_r), .trim_l_o(tr_l), .trim_r_o(tr_r),
    .chan_on_l_o(on_l), .chan_on_r_o(on_r));
  initial forever #4 clk_i = ~clk_i;
  function logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task bus(input logic w, input logic [6:0] idx, input logic [7:0] d);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= 4'h1;
    dat_i <= {24'h00_0000, d};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  task rd(input logic [6:0] idx, input logic [7:0] e);
    q.push_back(e);
    bus(0, idx, 8'h00);
  endtask
  // Sample strobes; expected outputs queued, right channel stays off
  task st(input int n);
    repeat (n) begin
      lfsr = nxt(lfsr);
      sq.push_back({on_e != 2, 16'h0000, on_e ? lfsr : 16'h0000});
      sv_i <= 1;
      sl_i <= lfsr;
      sr_i <= ~lfsr;
      @(posedge clk_i);
      sv_i <= 0;
      @(posedge clk_i);
    end
  endtask
  always @(posedge clk_i) if (ack_o === 1'b1 && we_i === 1'b0) check(dat_o, q.pop_front());
  always @(posedge clk_i) begin
    if (sv_o === 1'b1) begin
      se = sq.pop_front();
      if (se[32]) check(sl_o, se[15:0]);
      check(sr_o, se[31:16]);
    end
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 5000) begin
      fails++;
      end_sim;
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    check(pg_l, 0); check(mu_l, 1); check(dv_l, 7'h68); check(tr_l, 0); check(on_l, 0);
    check(pg_r, 7'h00);
    check(mu_r, 1'b1);
    check(on_r, 1'b0);
    rd(`ADCGC_IDX_FLAGS, 8'h88);
    foreach (ix[i]) rd(ix[i], 8'h00);
    bus(1, `ADCGC_IDX_FLAGS, 8'hff);
    rd(`ADCGC_IDX_FLAGS, 8'h88);
    rd(7'h10, 8'h00);
    bus(1, `ADCGC_IDX_TRIM, 8'h73);
    rd(`ADCGC_IDX_TRIM, 8'h43);
    check(tr_l, 4); check(tr_r, 3);
    $display("test registers done");
    bus(1, `ADCGC_IDX_CTRL, 8'h01);
    bus(1, `ADCGC_IDX_PGA_L, 8'h05);
    on_e = 1;
    for (int k = 1; k <= 24; k++) begin
      st(1);
      check(pg_l, (k > 6) ? 5 : k - 1);
      if (k == 10) rd(`ADCGC_IDX_FLAGS, 8'h08);
    end
    check(dv_l, 0); check(dv_r, 7'h68);
    rd(`ADCGC_IDX_FLAGS, 8'h88);
    bus(1, `ADCGC_IDX_STEP, 8'h01);
    bus(1, `ADCGC_IDX_DVOL_L, 8'h02);
    st(2);
    check(dv_l, 1);
    st(2);
    check(dv_l, 2);
    $display("test soft step done");
    bus(1, `ADCGC_IDX_STEP, 8'h02);
    bus(1, `ADCGC_IDX_PGA_L, 8'h7f);
    bus(1, `ADCGC_IDX_DVOL_L, 8'h50);
    check(pg_l, 7'h5f); check(dv_l, 7'h68);
    rd(`ADCGC_IDX_DVOL_L, 8'h50);
    agc_l <= 7'h20;
    agc_r <= 7'h60;
    bus(1, `ADCGC_IDX_CTRL, 8'h31);
    check(pg_l, 7'h20);
    check(pg_r, 7'h00);
    check(mu_r, 1'b1);
    $display("test immediate done");
    bus(1, `ADCGC_IDX_STEP, 8'h00);
    bus(1, `ADCGC_IDX_CTRL, 8'h00);
    on_e = 2;
    st(1);
    check(pg_l, 7'h1f); check(on_l, 1);
    for (int k = 0; k < 60 && on_l === 1'b1; k++) st(1);
    check(on_l, 0); check(mu_l, 1); check(dv_l, 7'h68);
    on_e = 0;
    st(1);
    rd(`ADCGC_IDX_STAT, 8'h00);
    $display("test power down done");
    end_sim;
  end
endmodule // adc_channel_gain_control_tb_top
`default_nettype wire
